// [common/pdsd_pkg.sv]
// Package for the pump drive status decoder: constants and carrier types
package pdsd_pkg;

   // ----------------------------------------------------------------
   // Timing and thresholds
   // ----------------------------------------------------------------
   localparam int unsigned PDSD_CLK_HZ = 100_000_000;
   localparam int unsigned PDSD_FLASH_HALF_MS = 250;
   localparam int unsigned PDSD_FLASH_HALF_CYC = PDSD_CLK_HZ / 1000 * PDSD_FLASH_HALF_MS;
   localparam int unsigned PDSD_AT_SPEED_PCT = 90;
   localparam int unsigned PDSD_FREQ_W = 16;

   // ----------------------------------------------------------------
   // Reset values of the outputs
   // ----------------------------------------------------------------
   localparam logic PDSD_RST_DRIVE = 1'b0;
   localparam logic PDSD_RST_RELAY = 1'b0;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {PDSD_ROT_OFF, PDSD_ROT_FLASH, PDSD_ROT_GREEN} pdsd_rot_mode_t;

   typedef struct packed {
      logic start_cmd;
      logic rotor_turning;
      logic error_present;
   } pdsd_in_t;

   typedef struct packed {
      logic motor_enable;
      logic at_speed_relay;
      logic fault_relay;
      logic rotation_indicator;
      logic fault_indicator;
   } pdsd_out_t;

endpackage

// [core/pdsd_decoder.sv]
// Status decoder for the pump drive: drive enable, relays and indicators
`timescale 1ns/100ps
// Function
// - Start, turning, at speed, no error: drive on, at-speed relay, green steady.
// - At-speed flag set when rotor frequency is at least 90 percent of setpoint.
// - Stop, no error, rotor turning: drive off, relays passive, rotation flashes.
// - Error, rotor stopped: drive off, fault relay active, red, rotation off.
// - Error, turning below speed: drive off, fault relay, red, rotation flashes.
// - Error while at speed: drive off, at-speed relay drops, fault relay, flash.
// - Any drive, relay or red indicator combination outside the legal table flags converter failure.
// - At-speed relay active means common to normally-open, else normally-closed.
// - Fault relay rests normally-closed without error, switches over on error.
module pdsd_decoder
   import pdsd_pkg::*;
#(
   parameter int unsigned FREQ_W = PDSD_FREQ_W,
   parameter int unsigned FLASH_HALF_CYC = PDSD_FLASH_HALF_CYC
) (
   // Clock, reset and freeze
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   // Commands and frequencies, sampled on every enabled edge
   input wire pdsd_in_t ctrl_in,
   input wire logic [FREQ_W-1:0] rotor_freq,
   input wire logic [FREQ_W-1:0] setpoint_freq,
   // Status outputs, all taken from flops
   output pdsd_out_t status_out,
   output logic at_speed,
   output logic at_speed_relay_no,
   output logic fault_relay_nc,
   output logic converter_fail
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Widened products so 90 percent compare never overflows
   // Cross-multiplied so no divider is needed for the threshold
   function automatic logic freq_at_speed(input logic [FREQ_W-1:0] f,
                                          input logic [FREQ_W-1:0] sp);
      logic [FREQ_W+6:0] lhs;
      logic [FREQ_W+6:0] rhs;
      lhs = (FREQ_W+7)'(f) * (FREQ_W+7)'(100);
      rhs = (FREQ_W+7)'(sp) * (FREQ_W+7)'(PDSD_AT_SPEED_PCT);
      return lhs >= rhs;
   endfunction

   // Legal output combinations of the status table
   function automatic logic legal_combo(input pdsd_out_t o, input pdsd_rot_mode_t m);
      logic ok;
      ok = 1'b0;
      // Fault side: drive off, at-speed relay passive, red lit, never steady green
      if (o.fault_relay) begin
         ok = !o.motor_enable && !o.at_speed_relay && o.fault_indicator && m != PDSD_ROT_GREEN;
      end else begin
         // No fault: at-speed relay exactly in steady green, and only with the drive on
         ok = !o.fault_indicator && (o.at_speed_relay == (m == PDSD_ROT_GREEN))
              && (!o.at_speed_relay || o.motor_enable);
      end
      return ok;
   endfunction

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   // Next values of the decode group
   logic at_speed_d;
   logic drive_d;
   logic speed_rel_d;
   logic fault_rel_d;
   logic fault_led_d;
   logic fault_nc_d;
   pdsd_rot_mode_t rot_mode_d;

   // Decode group registers
   logic at_speed_q;
   logic drive_q;
   logic speed_rel_q;
   logic fault_rel_q;
   logic fault_led_q;
   logic fault_nc_q;
   pdsd_rot_mode_t rot_mode_q;

   // Indicator, flash timebase and self check
   logic rot_led_q;
   logic rot_led_d;
   logic fail_q;
   logic fail_d;
   logic [31:0] flash_cnt_q;
   logic [31:0] flash_cnt_d;
   logic flash_ph_q;
   logic flash_ph_d;

   // Table decode; error dominates start so a fault always kills the drive
   always_comb begin
      at_speed_d = freq_at_speed(rotor_freq, setpoint_freq);
      drive_d = 1'b0;
      speed_rel_d = 1'b0;
      fault_rel_d = 1'b0;
      fault_led_d = 1'b0;
      rot_mode_d = PDSD_ROT_OFF;
      if (ctrl_in.error_present) begin
         fault_rel_d = 1'b1;
         fault_led_d = 1'b1;
         // Turning with error, at or below speed, flashes
         rot_mode_d = ctrl_in.rotor_turning ? PDSD_ROT_FLASH : PDSD_ROT_OFF;
      end else if (!ctrl_in.rotor_turning) begin
         // Standstill without error: drive follows start, all else dark
         drive_d = ctrl_in.start_cmd;
      end else if (ctrl_in.start_cmd && at_speed_d) begin
         // Normal operation, the only state with the at-speed relay active
         drive_d = 1'b1;
         speed_rel_d = 1'b1;
         rot_mode_d = PDSD_ROT_GREEN;
      end else begin
         // Run-up, or coasting down after stop; drive still follows start
         drive_d = ctrl_in.start_cmd;
         rot_mode_d = PDSD_ROT_FLASH;
      end
      // Break contact mirrors the relay so both poles switch on one edge
      fault_nc_d = !fault_rel_d;
   end

   // ----------------------------------------------------------------
   // Flash timebase and rotation indicator
   // ----------------------------------------------------------------
   // Flash timebase; free running so all flashing states share one phase
   always_comb begin
      flash_cnt_d = flash_cnt_q;
      flash_ph_d = flash_ph_q;
      // Wrap one count early so each phase lasts FLASH_HALF_CYC cycles
      if (flash_cnt_q >= FLASH_HALF_CYC - 1) begin
         flash_cnt_d = 32'h0000_0000;
         flash_ph_d = !flash_ph_q;
      end else begin
         flash_cnt_d = flash_cnt_q + 32'h0000_0001;
      end
      // Indicator trails the mode by one flop; steady green ignores the phase
      case (rot_mode_q)
         PDSD_ROT_OFF: rot_led_d = 1'b0;
         PDSD_ROT_FLASH: rot_led_d = flash_ph_q;
         PDSD_ROT_GREEN: rot_led_d = 1'b1;
         default: rot_led_d = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Self check
   // ----------------------------------------------------------------
   // Self check over the registered outputs; latches until reset
   always_comb begin
      fail_d = fail_q;
      if (!legal_combo('{motor_enable: drive_q, at_speed_relay: speed_rel_q,
                         fault_relay: fault_rel_q, rotation_indicator: rot_led_q,
                         fault_indicator: fault_led_q}, rot_mode_q)) begin
         fail_d = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Decode group; reset parks the drive off and both relays passive
   always_ff @(posedge clk) begin
      if (rst) begin
         at_speed_q <= 1'b0;
         drive_q <= PDSD_RST_DRIVE;
         speed_rel_q <= PDSD_RST_RELAY;
         fault_rel_q <= PDSD_RST_RELAY;
         fault_nc_q <= !PDSD_RST_RELAY;
         fault_led_q <= 1'b0;
         rot_mode_q <= PDSD_ROT_OFF;
      end else if (clk_en) begin
         at_speed_q <= at_speed_d;
         drive_q <= drive_d;
         speed_rel_q <= speed_rel_d;
         fault_rel_q <= fault_rel_d;
         fault_nc_q <= fault_nc_d;
         fault_led_q <= fault_led_d;
         rot_mode_q <= rot_mode_d;
      end
   end

   // Flash group; frozen with the rest so the phase never slips under clk_en
   always_ff @(posedge clk) begin
      if (rst) begin
         rot_led_q <= 1'b0;
         flash_cnt_q <= 32'h0000_0000;
         flash_ph_q <= 1'b0;
      end else if (clk_en) begin
         rot_led_q <= rot_led_d;
         flash_cnt_q <= flash_cnt_d;
         flash_ph_q <= flash_ph_d;
      end
   end

   // Check group; sticky so a one-cycle illegal pattern is never lost
   always_ff @(posedge clk) begin
      if (rst) begin
         fail_q <= 1'b0;
      end else if (clk_en) begin
         fail_q <= fail_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Outputs straight from flops
   assign status_out.motor_enable = drive_q;
   assign status_out.at_speed_relay = speed_rel_q;
   assign status_out.fault_relay = fault_rel_q;
   assign status_out.rotation_indicator = rot_led_q;
   assign status_out.fault_indicator = fault_led_q;
   assign at_speed = at_speed_q;
   assign at_speed_relay_no = speed_rel_q;   // Common to normally-open when active
   assign fault_relay_nc = fault_nc_q;       // Own flop, no inverter after it
   assign converter_fail = fail_q;

endmodule // pdsd_decoder

// [tb/pdsd_decoder_chk.sv]
// Assertions on the status decoder ports
`timescale 1ns/100ps
module pdsd_decoder_chk
   import pdsd_pkg::*;
#(parameter int unsigned FREQ_W = PDSD_FREQ_W) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire pdsd_in_t ctrl_in,
   input wire logic [FREQ_W-1:0] rotor_freq,
   input wire logic [FREQ_W-1:0] setpoint_freq,
   input wire pdsd_out_t status_out,
   input wire logic at_speed,
   input wire logic at_speed_relay_no,
   input wire logic fault_relay_nc,
   input wire logic converter_fail
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Widened so the products cannot wrap
   wire logic cmp = 32'(rotor_freq) * 100 >= 32'(setpoint_freq) * 90;
   wire logic [3:0] o = {status_out[4:2], status_out[0]};
   // Inputs steady and running, so either compare pipeline has settled
   sequence s_calm;
      !$past(rst) && !$past(rst, 2) && $past(clk_en) && $past(clk_en, 2) &&
      $past(ctrl_in) == $past(ctrl_in, 2) && $past(cmp) == $past(cmp, 2) &&
      $past(cmp, 2) == $past(cmp, 3);
   endsequence
   sequence s_run;
      clk_en && !rst && ctrl_in == 3'h6 && cmp;
   endsequence
   chk_normal_run: assert property (
      s_calm ##0 ($past(ctrl_in) == 3'h6 && $past(cmp)) |-> o == 4'hc)
      else $error("normal run outputs wrong");
   chk_speed_flag: assert property (
      !$past(rst) && $past(clk_en) |-> at_speed == $past(cmp))
      else $error("at-speed flag wrong");
   chk_error_wins: assert property (
      s_calm ##0 $past(ctrl_in.error_present) |-> o == 4'h3)
      else $error("error outputs wrong");
   chk_drive_follow: assert property (
      s_calm ##0 (($past(ctrl_in) != 3'h6 || !$past(cmp)) && !$past(ctrl_in.error_present))
      |-> o == {$past(ctrl_in.start_cmd), 3'h0})
      else $error("drive follow outputs wrong");
   chk_rot_dark: assert property (
      (clk_en && !rst && !ctrl_in.rotor_turning) [*4] |-> !status_out.rotation_indicator)
      else $error("rotation lit while stopped");
   chk_rot_green: assert property (
      s_run [*4] |-> status_out.rotation_indicator)
      else $error("rotation not steady");
   chk_fail_quiet: assert property (!converter_fail)
      else $error("converter failure raised");
   // Table shape: red pairs with the fault relay, which excludes drive and at-speed relay
   chk_legal_combo: assert property (
      o[1] == o[0] && !(o[1] && (o[3] || o[2])) && (!o[2] || o[3]))
      else $error("illegal output combination");
   chk_relay_poles: assert property (
      at_speed_relay_no == status_out[3] && fault_relay_nc == !status_out[2])
      else $error("relay contacts disagree");
endmodule // pdsd_decoder_chk
bind pdsd_decoder pdsd_decoder_chk #(.FREQ_W(FREQ_W)) pdsd_decoder_chk_i (.clk(clk), .rst(rst),
   .clk_en(clk_en), .ctrl_in(ctrl_in), .rotor_freq(rotor_freq), .setpoint_freq(setpoint_freq),
   .status_out(status_out), .at_speed(at_speed), .at_speed_relay_no(at_speed_relay_no),
   .fault_relay_nc(fault_relay_nc), .converter_fail(converter_fail));

// [tb/pdsd_ctrl_model.sv]
// Controller model: start command, cooling valve, cable permit
`timescale 1ns/100ps
module pdsd_ctrl_model #(parameter int unsigned DARK_CYC = 16) (
   input wire logic clk,
   input wire logic run_req,
   input wire logic rot_lit,
   output logic start_cmd = 1'b0,
   output logic valve_on = 1'b0,
   output logic cable_ok = 1'b0
);
   logic [7:0] dark_cnt = 8'h00;
   // Valve moves on the same edge as the pump command
   always @(posedge clk) begin
      start_cmd <= run_req;
      valve_on <= run_req;
   end
   // Permit only after a dark spell longer than any flash phase
   always @(posedge clk) begin
      if (rot_lit) begin
         dark_cnt <= 8'h00;
      end else if (dark_cnt < 8'(DARK_CYC)) begin
         dark_cnt <= dark_cnt + 8'h01;
      end
      cable_ok <= !rot_lit && dark_cnt >= 8'(DARK_CYC - 1);
   end
endmodule // pdsd_ctrl_model

// [tb/pdsd_decoder_tb.sv]
// Testbench for the pump drive status decoder
`timescale 1ns/100ps
module pdsd_decoder_tb;
   import pdsd_pkg::*;
   logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, run = 1'b0, turn = 1'b0, err = 1'b0;
   logic start, valve, cab, spd, asno, frnc, fail;
   logic [15:0] rf = 16'h0000, sp = 16'h03e8;
   pdsd_out_t so;
   int fail_count = 0, total_checks = 0;
   always #5 clk = ~clk;
   // Dark spell of three flash phases before cables may be touched
   pdsd_ctrl_model #(.DARK_CYC(12)) pdsd_ctrl_model_i (.clk(clk), .run_req(run),
      .rot_lit(so.rotation_indicator), .start_cmd(start), .valve_on(valve), .cable_ok(cab));
   // Short flash half period keeps the run brief
   pdsd_decoder #(.FLASH_HALF_CYC(4)) pdsd_decoder_i (.clk(clk), .rst(rst), .clk_en(clk_en),
      .ctrl_in({start, turn, err}), .rotor_freq(rf), .setpoint_freq(sp), .status_out(so),
      .at_speed(spd), .at_speed_relay_no(asno), .fault_relay_nc(frnc), .converter_fail(fail));
   task automatic chk(string n, logic [7:0] e, logic [7:0] s);
      total_checks++;
      if (s !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // One table row: {start, turning, at speed, error}; 900 of 1000 sits on the threshold
   task automatic step(logic [3:0] c);
      int lit;
      logic [7:0] e, r;
      lit = 0;
      e = c[0] ? 8'h03 : {4'h0, c[3], &c[3:1], 2'h0};
      r = !c[2] ? 8'h00 : (!c[0] && &c[3:1]) ? 8'h10 : 8'h08;
      @(posedge clk);
      run <= c[3];
      turn <= c[2];
      err <= c[0];
      rf <= c[1] ? 16'h0384 : 16'h0383;
      repeat (6) @(posedge clk);
      repeat (16) begin
         @(negedge clk);
         lit += int'(so.rotation_indicator === 1'b1);
      end
      chk("outputs", e, {4'h0, so[4:2], so[0]});
      chk("rotation", r, 8'(lit));
      chk("at_speed", {7'h0, c[1]}, {7'h0, spd});
      chk("valve", {7'h0, c[3]}, {7'h0, valve});
      chk("contacts", {6'h0, !c[0] && &c[3:1], !c[0]}, {6'h0, asno, frnc});
      chk("fail", 8'h00, {7'h0, fail});
      chk("cable", {7'h0, !c[2]}, {7'h0, cab});
      $display("test %h done", c);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         if (i[2] || !i[1]) step(4'(i));
      end
      step(4'he);
      // Frozen block must ignore a new error
      @(posedge clk);
      clk_en <= 1'b0;
      err <= 1'b1;
      repeat (6) @(negedge clk);
      chk("frozen", 8'h0c, {4'h0, so[4:2], so[0]});
      @(posedge clk);
      clk_en <= 1'b1;
      rst <= 1'b1;
      repeat (2) @(negedge clk);
      chk("reset", 8'h01, {2'h0, so, frnc});
      $display("test freeze and reset done");
      print_verdict;
   end
   // Watchdog well past the roughly 320 cycles needed
   initial begin
      #50us;
      fail_count++;
      print_verdict;
   end
endmodule // pdsd_decoder_tb
